// [core/intc_pkg.sv]
// Operation
// - each enabled source routes to any of four destinations, same bit everywhere
// - destinations zero and one drive the processor interrupt inputs
// - destinations two and three leave the chip as pins or inband requests
// - bit 0 is high when any port module is active and enabled
// - port modules have raw, bypass, trigger, event log, enable and active view
// - external inputs and outputs have polarity; outputs have a drive mode
// - external inputs zero and one sit at bits 1 and 2
// - timers zero, one, two sit at bits 3, 4, 5
// - first and second async serial interrupts sit at bits 6 and 7
// - two-wire controllers sit at bits 8 and 9
// - serial master controller sits at bit 10
// - software interrupts sit at bits 11 and 12
// - serial pin interrupts sit at bits 13, 14, 15
// - parallel pin interrupt sits at bit 16
// - management controllers sit at bits 17, 18, 19
// - frame DMA sits at bit 20
// - analyzer sits at bit 21
// - timestamp ready at bit 22, time sync at bit 23
// - extraction ready at bit 25, injection ready at bit 26
// - PCIe interrupt sits at bit 27
// - OAM endpoint interrupt sits at bit 28
// - event log sets on level, any edge, falling or rising per trigger
// - writing one clears an event log bit; a fresh event wins
// - each destination passes only masked sources and shows them
// - logic is active high; polarity fixed outside the core path
package intc_pkg;
  localparam int SRC_W = 29;
  localparam int DST_N = 4;
  // source bit positions
  localparam int B_PORT = 0;
  localparam int B_EXT0 = 1;
  localparam int B_EXT1 = 2;
  localparam int B_TMR0 = 3;
  localparam int B_UART0 = 6;
  localparam int B_TWOWIRE0 = 8;
  localparam int B_SMC = 10;
  localparam int B_SOFT0 = 11;
  localparam int B_SPIN0 = 13;
  localparam int B_PIN = 16;
  localparam int B_MGMT0 = 17;
  localparam int B_DMA = 20;
  localparam int B_ANALYZER = 21;
  localparam int B_TSR = 22;
  localparam int B_TSYNC = 23;
  localparam int B_RSVD = 24;
  localparam int B_XTR = 25;
  localparam int B_INJ = 26;
  localparam int B_PCIE = 27;
  localparam int B_OAM = 28;
  // register word offsets (byte addresses)
  localparam logic [7:0] A_RAW = 8'h00;
  localparam logic [7:0] A_BYPASS = 8'h04;
  localparam logic [7:0] A_TRIG_LO = 8'h08;
  localparam logic [7:0] A_TRIG_HI = 8'h0c;
  localparam logic [7:0] A_STICKY = 8'h10;
  localparam logic [7:0] A_ENA = 8'h14;
  localparam logic [7:0] A_IDENT = 8'h18;
  localparam logic [7:0] A_MAP0 = 8'h20;
  localparam logic [7:0] A_DIDENT0 = 8'h30;
  localparam logic [7:0] A_M_RAW = 8'h40;
  localparam logic [7:0] A_M_BYPASS = 8'h44;
  localparam logic [7:0] A_M_TRIG_LO = 8'h48;
  localparam logic [7:0] A_M_TRIG_HI = 8'h4c;
  localparam logic [7:0] A_M_STICKY = 8'h50;
  localparam logic [7:0] A_M_ENA = 8'h54;
  localparam logic [7:0] A_M_IDENT = 8'h58;
  localparam logic [7:0] A_M_POL = 8'h5c;
  localparam logic [7:0] A_EXT_IN_POL = 8'h60;
  localparam logic [7:0] A_EXT_OUT_POL = 8'h64;
  localparam logic [7:0] A_EXT_DRV = 8'h68;
  // trigger encodings
  localparam logic [1:0] TRG_LEVEL = 2'h0;
  localparam logic [1:0] TRG_ANY = 2'h1;
  localparam logic [1:0] TRG_FALL = 2'h2;
  localparam logic [1:0] TRG_RISE = 2'h3;
  typedef enum logic [1:0] {BUS_IDLE = 2'h0, BUS_ACK = 2'h1} bus_state_t;
endpackage : intc_pkg

// [core/switch_interrupt_controller.sv]
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module switch_interrupt_controller #(
  parameter int MOD_N = 16
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [MOD_N-1:0]  port_module_irq,
  input  wire logic              external_input_zero,
  input  wire logic              external_input_one,
  input  wire logic              timer_zero_irq,
  input  wire logic              timer_one_irq,
  input  wire logic              timer_two_irq,
  input  wire logic              first_async_serial_irq,
  input  wire logic              second_async_serial_irq,
  input  wire logic              two_wire_irq,
  input  wire logic              second_two_wire_irq,
  input  wire logic              serial_master_irq,
  input  wire logic              software_irq_zero,
  input  wire logic              software_irq_one,
  input  wire logic              serial_pin_irq_zero,
  input  wire logic              serial_pin_irq_one,
  input  wire logic              serial_pin_irq_two,
  input  wire logic              parallel_pin_irq,
  input  wire logic              mgmt_ctrl_irq_zero,
  input  wire logic              mgmt_ctrl_irq_one,
  input  wire logic              mgmt_ctrl_irq_two,
  input  wire logic              frame_dma_irq,
  input  wire logic              analyzer_irq,
  input  wire logic              timestamp_ready_irq,
  input  wire logic              time_sync_irq,
  input  wire logic              extraction_ready_irq,
  input  wire logic              injection_ready_irq,
  input  wire logic              pcie_irq,
  input  wire logic              oam_endpoint_irq,
  output logic                   cpu_irq_zero,
  output logic                   cpu_irq_one,
  output logic [1:0]             ext_irq_out,
  output logic [1:0]             ext_irq_oe,
  output logic [1:0]             pcie_inband_irq
);
  localparam int SW = intc_pkg::SRC_W;

  // refuse module counts that one 32-bit register word cannot hold
  if (MOD_N < 1 || MOD_N > 32) begin : g_bad_mod_n
    $error("MOD_N must be 1..32");
  end

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [SW-1:0]      bypass_r, ena_r, sticky_r, src_prev_r;
  logic [2*SW-1:0]    trig_r;
  logic [SW-1:0]      map_r [intc_pkg::DST_N];
  logic [MOD_N-1:0]   m_bypass_r, m_ena_r, m_sticky_r, m_prev_r, m_pol_r;
  logic [2*MOD_N-1:0] m_trig_r;
  logic [1:0]         in_pol_r, out_pol_r, drv_r;
  logic               wb_ack_r;
  logic [31:0]        wb_dat_r;
  intc_pkg::bus_state_t bus_r;

  // event detect shared by both hierarchies
  function automatic logic hit(input logic [1:0] trg, input logic cur, input logic prev);
    case (trg)
      intc_pkg::TRG_LEVEL: hit = cur;
      intc_pkg::TRG_ANY:   hit = cur ^ prev;
      intc_pkg::TRG_FALL:  hit = prev & ~cur;
      default:             hit = cur & ~prev;
    endcase
  endfunction : hit

  // ****************************************************************
  // port module hierarchy
  // ****************************************************************
  logic [MOD_N-1:0] m_raw, m_set, m_eff, m_ident;
  logic             wr_acc;
  // writes commit at the edge where the master samples ack, while it still holds the request
  assign wr_acc = wb_cyc_i & wb_stb_i & wb_we_i & (bus_r == intc_pkg::BUS_ACK);

  assign m_raw = port_module_irq ^ m_pol_r;

  genvar gm;
  generate
    for (gm = 0; gm < MOD_N; gm++) begin : g_mod
      assign m_set[gm] = hit(m_trig_r[2*gm +: 2], m_raw[gm], m_prev_r[gm]);
      assign m_eff[gm] = m_bypass_r[gm] ? m_raw[gm] : m_sticky_r[gm];
    end
  endgenerate
  assign m_ident = m_eff & m_ena_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      m_sticky_r <= '0;
      m_prev_r   <= '0;
    end else begin
      m_prev_r <= m_raw;
      if (wr_acc && wb_adr_i == intc_pkg::A_M_STICKY && wb_sel_i == 4'hf) begin
        m_sticky_r <= (m_sticky_r & ~wb_dat_i[MOD_N-1:0]) | m_set;
      end else begin
        m_sticky_r <= m_sticky_r | m_set;
      end
    end
  end

  // ****************************************************************
  // source assembly
  // ****************************************************************
  logic [SW-1:0] raw, set_ev, eff, ident;
  logic [1:0]    ext_in;
  logic [SW-1:0] dst_ident [intc_pkg::DST_N];
  assign ext_in = {external_input_one, external_input_zero} ^ in_pol_r;

  always_comb begin
    raw = '0;
    raw[intc_pkg::B_PORT] = |m_ident;
    raw[intc_pkg::B_EXT0] = ext_in[0];
    raw[intc_pkg::B_EXT1] = ext_in[1];
    raw[intc_pkg::B_TMR0 +: 3] = {timer_two_irq, timer_one_irq, timer_zero_irq};
    raw[intc_pkg::B_UART0 +: 2] = {second_async_serial_irq, first_async_serial_irq};
    raw[intc_pkg::B_TWOWIRE0 +: 2] = {second_two_wire_irq, two_wire_irq};
    raw[intc_pkg::B_SMC] = serial_master_irq;
    raw[intc_pkg::B_SOFT0 +: 2] = {software_irq_one, software_irq_zero};
    raw[intc_pkg::B_SPIN0 +: 3] = {serial_pin_irq_two, serial_pin_irq_one,
                                   serial_pin_irq_zero};
    raw[intc_pkg::B_PIN] = parallel_pin_irq;
    raw[intc_pkg::B_MGMT0 +: 3] = {mgmt_ctrl_irq_two, mgmt_ctrl_irq_one,
                                   mgmt_ctrl_irq_zero};
    raw[intc_pkg::B_DMA] = frame_dma_irq;
    raw[intc_pkg::B_ANALYZER] = analyzer_irq;
    raw[intc_pkg::B_TSR] = timestamp_ready_irq;
    raw[intc_pkg::B_TSYNC] = time_sync_irq;
    raw[intc_pkg::B_RSVD] = 1'b0;
    raw[intc_pkg::B_XTR] = extraction_ready_irq;
    raw[intc_pkg::B_INJ] = injection_ready_irq;
    raw[intc_pkg::B_PCIE] = pcie_irq;
    raw[intc_pkg::B_OAM] = oam_endpoint_irq;
  end

  genvar gs;
  generate
    for (gs = 0; gs < SW; gs++) begin : g_src
      assign set_ev[gs] = hit(trig_r[2*gs +: 2], raw[gs], src_prev_r[gs]);
      assign eff[gs] = bypass_r[gs] ? raw[gs] : sticky_r[gs];
    end
  endgenerate
  assign ident = eff & ena_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sticky_r   <= '0;
      src_prev_r <= '0;
    end else begin
      src_prev_r <= raw;
      if (wr_acc && wb_adr_i == intc_pkg::A_STICKY && wb_sel_i == 4'hf) begin
        sticky_r <= (sticky_r & ~wb_dat_i[SW-1:0]) | set_ev;
      end else begin
        sticky_r <= sticky_r | set_ev;
      end
    end
  end

  // ****************************************************************
  // destinations
  // ****************************************************************
  // per-destination mask
  genvar gd;
  generate
    for (gd = 0; gd < intc_pkg::DST_N; gd++) begin : g_dst
      assign dst_ident[gd] = ident & map_r[gd];
    end
  endgenerate

  logic [intc_pkg::DST_N-1:0] dst_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dst_r <= '0;
    end else begin
      for (int d = 0; d < intc_pkg::DST_N; d++) begin
        dst_r[d] <= |dst_ident[d];
      end
    end
  end

  assign cpu_irq_zero = dst_r[0];
  assign cpu_irq_one = dst_r[1];
  // off-chip lines; polarity and open-collector emulation on the pins only, inband lines pass unchanged
  assign pcie_inband_irq = dst_r[3:2];
  always_comb begin
    for (int e = 0; e < 2; e++) begin
      ext_irq_out[e] = dst_r[e+2] ^ out_pol_r[e];
      ext_irq_oe[e] = drv_r[e] ? ~ext_irq_out[e] : 1'b1;
    end
  end

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    rd_mux = '0;
    case (a)
      intc_pkg::A_RAW:         rd_mux[SW-1:0] = raw;
      intc_pkg::A_BYPASS:      rd_mux[SW-1:0] = bypass_r;
      intc_pkg::A_TRIG_LO:     rd_mux = trig_r[31:0];
      intc_pkg::A_TRIG_HI:     rd_mux[2*SW-33:0] = trig_r[2*SW-1:32];
      intc_pkg::A_STICKY:      rd_mux[SW-1:0] = sticky_r;
      intc_pkg::A_ENA:         rd_mux[SW-1:0] = ena_r;
      intc_pkg::A_IDENT:       rd_mux[SW-1:0] = ident;
      intc_pkg::A_M_RAW:       rd_mux[MOD_N-1:0] = m_raw;
      intc_pkg::A_M_BYPASS:    rd_mux[MOD_N-1:0] = m_bypass_r;
      intc_pkg::A_M_TRIG_LO:   rd_mux = 32'(m_trig_r);
      intc_pkg::A_M_TRIG_HI:   rd_mux = 32'(m_trig_r >> 32);
      intc_pkg::A_M_STICKY:    rd_mux[MOD_N-1:0] = m_sticky_r;
      intc_pkg::A_M_ENA:       rd_mux[MOD_N-1:0] = m_ena_r;
      intc_pkg::A_M_IDENT:     rd_mux[MOD_N-1:0] = m_ident;
      intc_pkg::A_M_POL:       rd_mux[MOD_N-1:0] = m_pol_r;
      intc_pkg::A_EXT_IN_POL:  rd_mux[1:0] = in_pol_r;
      intc_pkg::A_EXT_OUT_POL: rd_mux[1:0] = out_pol_r;
      intc_pkg::A_EXT_DRV:     rd_mux[1:0] = drv_r;
      default: begin
        for (int d = 0; d < intc_pkg::DST_N; d++) begin
          if (a == intc_pkg::A_MAP0 + 8'(4*d)) rd_mux[SW-1:0] = map_r[d];
          if (a == intc_pkg::A_DIDENT0 + 8'(4*d)) rd_mux[SW-1:0] = dst_ident[d];
        end
      end
    endcase
  endfunction : rd_mux

  // one-cycle ack; unmapped reads return zero, writes ignored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_r    <= intc_pkg::BUS_IDLE;
      wb_ack_r <= 1'b0;
      wb_dat_r <= '0;
    end else if (bus_r == intc_pkg::BUS_IDLE && wb_cyc_i && wb_stb_i) begin
      bus_r    <= intc_pkg::BUS_ACK;
      wb_ack_r <= 1'b1;
      wb_dat_r <= rd_mux(wb_adr_i);
    end else begin
      bus_r    <= intc_pkg::BUS_IDLE;
      wb_ack_r <= 1'b0;
    end
  end
  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;

  // configuration writes; full-word only for simplicity
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bypass_r   <= '0;
      trig_r     <= '0;
      ena_r      <= '0;
      m_bypass_r <= '0;
      m_trig_r   <= '0;
      m_ena_r    <= '0;
      m_pol_r    <= '0;
      in_pol_r   <= '0;
      out_pol_r  <= '0;
      drv_r      <= '0;
      for (int d = 0; d < intc_pkg::DST_N; d++) map_r[d] <= '0;
    end else if (wr_acc && wb_sel_i == 4'hf) begin
      case (wb_adr_i)
        intc_pkg::A_BYPASS:      bypass_r <= wb_dat_i[SW-1:0];
        intc_pkg::A_TRIG_LO:     trig_r[31:0] <= wb_dat_i;
        intc_pkg::A_TRIG_HI:     trig_r[2*SW-1:32] <= wb_dat_i[2*SW-33:0];
        intc_pkg::A_ENA:         ena_r <= wb_dat_i[SW-1:0] & ~(SW'(1) << intc_pkg::B_RSVD);
        intc_pkg::A_M_BYPASS:    m_bypass_r <= wb_dat_i[MOD_N-1:0];
        intc_pkg::A_M_TRIG_LO:   m_trig_r <= (m_trig_r & ~(2*MOD_N)'(32'hffffffff))
                                             | (2*MOD_N)'(wb_dat_i);
        intc_pkg::A_M_TRIG_HI:   m_trig_r <= (m_trig_r & (2*MOD_N)'(32'hffffffff))
                                             | (2*MOD_N)'({wb_dat_i, 32'h0} >> 0);
        intc_pkg::A_M_ENA:       m_ena_r <= wb_dat_i[MOD_N-1:0];
        intc_pkg::A_M_POL:       m_pol_r <= wb_dat_i[MOD_N-1:0];
        intc_pkg::A_EXT_IN_POL:  in_pol_r <= wb_dat_i[1:0];
        intc_pkg::A_EXT_OUT_POL: out_pol_r <= wb_dat_i[1:0];
        intc_pkg::A_EXT_DRV:     drv_r <= wb_dat_i[1:0];
        default: begin
          for (int d = 0; d < intc_pkg::DST_N; d++) begin
            if (wb_adr_i == intc_pkg::A_MAP0 + 8'(4*d)) map_r[d] <= wb_dat_i[SW-1:0];
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // reserved stays silent
  chk_rsvd_never: assert property (@(posedge clk) disable iff (sys_rst)
    !ident[intc_pkg::B_RSVD]) else $error("reserved bit active");
  chk_rsvd_ena: assert property (@(posedge clk) disable iff (sys_rst)
    !ena_r[intc_pkg::B_RSVD]) else $error("reserved enable set");
  chk_level_sets: assert property (@(posedge clk) disable iff (sys_rst)
    (trig_r[2*intc_pkg::B_TMR0 +: 2] == intc_pkg::TRG_LEVEL && timer_zero_irq)
    |=> sticky_r[intc_pkg::B_TMR0]) else $error("level event lost");
  chk_rise_sets: assert property (@(posedge clk) disable iff (sys_rst)
    (trig_r[2*intc_pkg::B_TMR0 +: 2] == intc_pkg::TRG_RISE && $rose(timer_zero_irq))
    |=> sticky_r[intc_pkg::B_TMR0]) else $error("rise event lost");
  chk_fall_sets: assert property (@(posedge clk) disable iff (sys_rst)
    (trig_r[2*intc_pkg::B_TMR0 +: 2] == intc_pkg::TRG_FALL && $fell(timer_zero_irq))
    |=> sticky_r[intc_pkg::B_TMR0]) else $error("fall event lost");
  chk_any_sets: assert property (@(posedge clk) disable iff (sys_rst)
    (trig_r[2*intc_pkg::B_TMR0 +: 2] == intc_pkg::TRG_ANY && $changed(timer_zero_irq))
    |=> sticky_r[intc_pkg::B_TMR0]) else $error("change event lost");
  chk_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
    set_ev[intc_pkg::B_SOFT0] |=> sticky_r[intc_pkg::B_SOFT0]) else $error("clear beat set");
  chk_mod_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
    m_set[0] |=> m_sticky_r[0]) else $error("module clear beat set");
  chk_clear_works: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_acc && wb_adr_i == intc_pkg::A_STICKY && wb_sel_i == 4'hf
     && wb_dat_i[intc_pkg::B_TMR0] && !set_ev[intc_pkg::B_TMR0])
    |=> !sticky_r[intc_pkg::B_TMR0]) else $error("write-one clear lost");
  chk_port_agg: assert property (@(posedge clk) disable iff (sys_rst)
    (|(m_sticky_r & m_ena_r & ~m_bypass_r)) |-> raw[intc_pkg::B_PORT])
    else $error("aggregate missed");
  chk_agg_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    !(|m_ident) |-> !raw[intc_pkg::B_PORT]) else $error("aggregate without module");
  chk_bypass_raw: assert property (@(posedge clk) disable iff (sys_rst)
    (bypass_r[intc_pkg::B_TMR0] && !raw[intc_pkg::B_TMR0]) |-> !ident[intc_pkg::B_TMR0])
    else $error("bypass used the log");
  chk_cpu_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (|(ident & map_r[0])) |=> cpu_irq_zero) else $error("cpu line zero missed");
  chk_cpu_one: assert property (@(posedge clk) disable iff (sys_rst)
    (|(ident & map_r[1])) |=> cpu_irq_one) else $error("cpu line one missed");
  chk_dst_mask: assert property (@(posedge clk) disable iff (sys_rst)
    (map_r[1] == '0) |=> !cpu_irq_one) else $error("unmapped source passed");
  chk_pcie_line: assert property (@(posedge clk) disable iff (sys_rst)
    (|(ident & map_r[3])) |=> pcie_inband_irq[1]) else $error("inband line missed");
  chk_ext_pol: assert property (@(posedge clk) disable iff (sys_rst)
    ext_irq_out[0] == (dst_r[2] ^ out_pol_r[0])) else $error("output polarity");
  chk_oe_drive: assert property (@(posedge clk) disable iff (sys_rst)
    !drv_r[1] |-> ext_irq_oe[1]) else $error("push-pull pin released");
  chk_ext_in_bit: assert property (@(posedge clk) disable iff (sys_rst)
    raw[intc_pkg::B_EXT1] == (external_input_one ^ in_pol_r[1]))
    else $error("external input bit");
endmodule : switch_interrupt_controller

// [bench/irq_source_model.sv]
`timescale 1ns/1ps
// ****************************************
// far side: interrupting blocks and processor
// ****************************************
module irq_source_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [28:0] want,
  input  wire logic        cpu_irq_zero,
  input  wire logic        cpu_irq_one,
  output logic      [28:0] src,
  output logic      [1:0]  cpu_seen
);
  // levels launch just after an edge, like the source flops would
  // active high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      src <= 29'h0;
    end else begin
      src <= want & ~(29'h1 << 24); // nothing ever drives the reserved bit
    end
  end
  // processor side keeps a note of every line it was offered
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_seen <= 2'h0;
    end else begin
      cpu_seen <= cpu_seen | {cpu_irq_one, cpu_irq_zero};
    end
  end
endmodule : irq_source_model

// [bench/switch_interrupt_controller_test.sv]
`timescale 1ns/1ps
// ****************************************
// bench top
// ****************************************
module switch_interrupt_controller_test;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [15:0] pm = 16'h0;
  logic [28:0] want = 29'h0;
  logic [31:0] q;
  wire  [31:0] rdat;
  wire         ack;
  wire         cpu0;
  wire         cpu1;
  wire  [1:0]  xo;
  wire  [1:0]  xoe;
  wire  [1:0]  pin;
  wire  [28:0] src;
  wire  [1:0]  cpu_seen;
  int          bad_count = 0;
  int          checks = 0;
  // free-running system clock
  always #2.5 clk = ~clk;
  irq_source_model i_far (.clk(clk), .sys_rst(sys_rst), .want(want), .cpu_irq_zero(cpu0),
    .cpu_irq_one(cpu1), .src(src), .cpu_seen(cpu_seen));
  switch_interrupt_controller #(.MOD_N(16)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .port_module_irq(pm),
    .external_input_zero(src[1]),
    .external_input_one(src[2]),
    .timer_zero_irq(src[3]),
    .timer_one_irq(src[4]),
    .timer_two_irq(src[5]),
    .first_async_serial_irq(src[6]),
    .second_async_serial_irq(src[7]),
    .two_wire_irq(src[8]),
    .second_two_wire_irq(src[9]),
    .serial_master_irq(src[10]),
    .software_irq_zero(src[11]),
    .software_irq_one(src[12]),
    .serial_pin_irq_zero(src[13]),
    .serial_pin_irq_one(src[14]),
    .serial_pin_irq_two(src[15]),
    .parallel_pin_irq(src[16]),
    .mgmt_ctrl_irq_zero(src[17]),
    .mgmt_ctrl_irq_one(src[18]),
    .mgmt_ctrl_irq_two(src[19]),
    .frame_dma_irq(src[20]),
    .analyzer_irq(src[21]),
    .timestamp_ready_irq(src[22]),
    .time_sync_irq(src[23]),
    .extraction_ready_irq(src[25]),
    .injection_ready_irq(src[26]),
    .pcie_irq(src[27]),
    .oam_endpoint_irq(src[28]),
    .cpu_irq_zero(cpu0), .cpu_irq_one(cpu1), .ext_irq_out(xo), .ext_irq_oe(xoe),
    .pcie_inband_irq(pin));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one classic cycle; the request stands until ack is sampled high, only the watchdog ends a wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(q, exp);
  endtask : rd
  task automatic pause(input int k);
    repeat (k) @(posedge clk);
  endtask : pause
  task automatic conclude();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  // watchdog: the whole sequence needs about a thousand cycles
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    pause(6);
    sys_rst <= 1'b0;
    pause(1);
    rd(intc_pkg::A_STICKY, 32'h0);
    chk(32'(xoe), 32'h3);
    wr(intc_pkg::A_ENA, 32'hffffffff);
    rd(intc_pkg::A_ENA, 32'h1effffff);
    wr(intc_pkg::A_MAP0, 32'hffffffff);
    for (int n = 1; n < 29; n++) begin
      if (n != intc_pkg::B_RSVD) begin
        want <= 29'h1 << n;
        pause(4);
        rd(intc_pkg::A_RAW, 32'h1 << n);
        rd(intc_pkg::A_IDENT, 32'h1 << n);
        chk(32'(cpu0), 32'h1);
        chk(32'(cpu1), 32'h0);
        want <= 29'h0;
        pause(4);
        wr(intc_pkg::A_STICKY, 32'hffffffff);
        rd(intc_pkg::A_STICKY, 32'h0);
      end
    end
    want <= 29'h1fffffff;
    pause(4);
    rd(intc_pkg::A_STICKY, 32'h1efffffe);
    want <= 29'h0;
    pause(4);
    wr(intc_pkg::A_STICKY, 32'hffffffff);
    wr(intc_pkg::A_M_ENA, 32'h20);
    pm <= 16'h0020;
    pause(4);
    rd(intc_pkg::A_M_IDENT, 32'h20);
    rd(intc_pkg::A_STICKY, 32'h1);
    pm <= 16'h0;
    wr(intc_pkg::A_M_POL, 32'h1);
    pause(4);
    rd(intc_pkg::A_M_RAW, 32'h1);
    wr(intc_pkg::A_M_POL, 32'h0);
    wr(intc_pkg::A_M_STICKY, 32'hffffffff);
    wr(intc_pkg::A_STICKY, 32'hffffffff);
    rd(intc_pkg::A_STICKY, 32'h0);
    // every trigger mode on timer zero
    for (int m = 0; m < 4; m++) begin
      wr(intc_pkg::A_TRIG_LO, 32'(m) << 6);
      want[3] <= 1'b1;
      pause(4);
      rd(intc_pkg::A_STICKY, (2'(m) != intc_pkg::TRG_FALL) ? 32'h8 : 32'h0);
      wr(intc_pkg::A_STICKY, 32'h8);
      rd(intc_pkg::A_STICKY, (2'(m) == intc_pkg::TRG_LEVEL) ? 32'h8 : 32'h0);
      want[3] <= 1'b0;
      pause(4);
      rd(intc_pkg::A_STICKY, (2'(m) == intc_pkg::TRG_RISE) ? 32'h0 : 32'h8);
      wr(intc_pkg::A_STICKY, 32'h8);
    end
    wr(intc_pkg::A_TRIG_LO, 32'h0);
    // bypass follows the raw level, not the log
    wr(intc_pkg::A_BYPASS, 32'h8);
    want[3] <= 1'b1;
    pause(4);
    want[3] <= 1'b0;
    pause(4);
    rd(intc_pkg::A_IDENT, 32'h0);
    wr(intc_pkg::A_BYPASS, 32'h0);
    wr(intc_pkg::A_EXT_IN_POL, 32'h3);
    pause(4);
    rd(intc_pkg::A_RAW, 32'h6);
    wr(intc_pkg::A_EXT_IN_POL, 32'h0);
    wr(intc_pkg::A_STICKY, 32'hffffffff);
    want[3] <= 1'b1;
    for (int d = 0; d < 4; d++) begin
      for (int e = 0; e < 4; e++) wr(intc_pkg::A_MAP0 + 8'(4 * e), (e == d) ? 32'h8 : 32'h0);
      pause(3);
      chk(32'(cpu0), 32'(d == 0));
      chk(32'(cpu1), 32'(d == 1));
      chk(32'(pin), (d >= 2) ? 32'h1 << (d - 2) : 32'h0);
      chk(32'(xo), (d >= 2) ? 32'h1 << (d - 2) : 32'h0);
      rd(intc_pkg::A_DIDENT0 + 8'(4 * d), 32'h8);
    end
    wr(intc_pkg::A_EXT_OUT_POL, 32'h3);
    pause(3);
    chk(32'(xo), 32'h1);
    chk(32'(pin), 32'h2);
    wr(intc_pkg::A_EXT_OUT_POL, 32'h0);
    wr(intc_pkg::A_EXT_DRV, 32'h3);
    pause(3);
    chk(32'(xoe), 32'h1);
    // unmapped read and partial write are refused
    rd(8'hfc, 32'h0);
    wb(1'b1, intc_pkg::A_ENA, 32'h0, 4'h3);
    rd(intc_pkg::A_ENA, 32'h1effffff);
    chk(32'(cpu_seen), 32'h3);
    // module rising trigger, then bypass on a held module line
    wr(intc_pkg::A_M_TRIG_LO, 32'hc00);
    rd(intc_pkg::A_M_TRIG_LO, 32'hc00);
    pm <= 16'h0020;
    pause(4);
    rd(intc_pkg::A_M_STICKY, 32'h20);
    wr(intc_pkg::A_M_STICKY, 32'h20);
    rd(intc_pkg::A_M_STICKY, 32'h0);
    wr(intc_pkg::A_M_BYPASS, 32'h20);
    rd(intc_pkg::A_M_IDENT, 32'h20);
    pm <= 16'h0;
    rd(intc_pkg::A_M_IDENT, 32'h0);
    // upper trigger word holds only the fields of bits 16 to 28
    wr(intc_pkg::A_TRIG_HI, 32'hffffffff);
    rd(intc_pkg::A_TRIG_HI, 32'h3ffffff);
    conclude();
  end
endmodule : switch_interrupt_controller_test
